// ### pkg/dci_map.svh
`ifndef DCI_MAP_SVH
`define DCI_MAP_SVH
// Command field upper nibble codes
`define DCI_NIB_READ0     4'h0
`define DCI_NIB_READ1     4'h1
`define DCI_NIB_STATUS    4'h2
`define DCI_NIB_WRITE0    4'h4
`define DCI_NIB_WRITE1    4'h5
`define DCI_NIB_CONTROL   4'h6
// Device reset full command byte (maker fixed)
`define DCI_CMD_DEVRESET  8'h2f
// Interrupt condition codes
`define DCI_CC_CTL_END    3'h0
`define DCI_CC_EXCEPTION  3'h2
`define DCI_CC_DEV_END    3'h3
`define DCI_CC_ATTENTION  3'h4
`define DCI_CC_ATTN_EXC   3'h6
`define DCI_CC_ATTN_END   3'h7
// Status byte field positions, bit 0 being the most significant
`define DCI_ISB_DDS_BIT   0
`define DCI_ISB_REJ_BIT   1
`define DCI_ISB_RST       8'h00
`endif

// ### pkg/dci_pkg.sv
package dci_pkg;
    typedef enum logic [2:0] {
        DCI_CMD_NONE     = 3'b000,
        DCI_CMD_READ     = 3'b001,
        DCI_CMD_STATUS   = 3'b010,
        DCI_CMD_WRITE    = 3'b011,
        DCI_CMD_CONTROL  = 3'b100,
        DCI_CMD_DEVRESET = 3'b101,
        DCI_CMD_RESERVED = 3'b110
    } dci_cmd_e;

    // Immediate control block as issued by the channel
    typedef struct packed {
        logic [7:0]  command;
        logic [7:0]  address;
        logic [15:0] data;
    } dci_icb_s;

    // Interrupt presented by an attached device
    typedef struct packed {
        logic [2:0]  cc;
        logic [7:0]  info;
        logic [7:0]  address;
        logic        singular;
    } dci_irq_s;

    // Interrupt word toward the channel
    typedef struct packed {
        logic [2:0]  cc;
        logic [15:0] word;
    } dci_ipres_s;
endpackage : dci_pkg

// ### core/dci_decode.sv
`timescale 1ns/1ns
`include "dci_map.svh"
module dci_decode
    import dci_pkg::*;
(
    input  wire logic [7:0] command,
    output dci_pkg::dci_cmd_e kind
);
    always_comb begin
        if (command == `DCI_CMD_DEVRESET) begin
            kind = DCI_CMD_DEVRESET;
        end else begin
            unique case (command[7:4])
                `DCI_NIB_READ0, `DCI_NIB_READ1: kind = DCI_CMD_READ;
                `DCI_NIB_STATUS:  kind = DCI_CMD_STATUS;
                `DCI_NIB_WRITE0, `DCI_NIB_WRITE1: kind = DCI_CMD_WRITE;
                `DCI_NIB_CONTROL: kind = DCI_CMD_CONTROL;
                default:          kind = DCI_CMD_RESERVED;
            endcase
        end
    end
endmodule : dci_decode

// ### core/dci_core.sv
`timescale 1ns/1ns
`include "dci_map.svh"
// Operation
// - Device reset resets device, clears its interrupts
// - Upper command nibble selects command type
// - Read data moves device word to block
// - Read status moves device status to block
// - Write data delivers block word to device
// - Write control starts device action, optional word
// - Busy controller later presents code 0, info zero
// - Controller-free address is lowest served address
// - Interrupt word: info byte, then address
// - Status byte only with codes 2, 6
// - Presented status byte nonzero unless singular
// - Errors set status byte; acceptance clears it
// - Status bit0 status available, bit1 reject
// - Resets clear mode, diag and status registers
// - Only device reset is a maker command
module dci_core
    import dci_pkg::*;
#(
    parameter logic [7:0] GROUP_LOW_ADDR = 8'h00
)(
    input  wire logic             clk,
    input  wire logic             rstn,
    // Channel side
    input  wire logic             icb_valid,
    input  dci_pkg::dci_icb_s     icb,
    output logic                  icb_done,
    output logic [15:0]           icb_rdata,
    output logic                  icb_busy_cc6,
    output logic                  icb_reject,
    input  wire logic             sys_reset,
    input  wire logic             halt_io,
    input  wire logic             machine_check,
    input  wire logic             diag_set,
    output logic                  diag_mode,
    output logic [15:0]           diag_reg,
    output logic [15:0]           status_reg,
    output logic                  irq_req,
    output dci_pkg::dci_ipres_s   irq_pres,
    input  wire logic             irq_ack,
    // Device side
    output logic                  dev_strobe,
    output dci_pkg::dci_cmd_e     dev_kind,
    output logic [7:0]            dev_command,
    output logic [7:0]            dev_address,
    output logic [15:0]           dev_wdata,
    output logic                  dev_reset,
    input  wire logic             dev_ready,
    input  wire logic [15:0]      dev_rdata,
    input  wire logic             dev_busy,
    input  wire logic             dev_irq_valid,
    input  dci_pkg::dci_irq_s     dev_irq,
    output logic                  dev_irq_ready
);
    import dci_pkg::*;

    typedef enum logic [1:0] {
        DCI_ST_IDLE = 2'b00,
        DCI_ST_WAIT = 2'b01
    } dci_state_e;

    dci_state_e   state;
    dci_cmd_e     kind;
    logic         clr_all;
    logic         pend;
    logic         ctl_end_owed;
    logic [7:0]   interrupt_status_byte;
    logic [7:0]   pend_addr;

    assign clr_all = !rstn || sys_reset || halt_io || machine_check;

    dci_decode dci_decode_i (
        .command (icb.command),
        .kind    (kind)
    );

    // Codes that may carry the status byte
    function automatic logic uses_isb(input logic [2:0] cc);
        uses_isb = (cc == `DCI_CC_EXCEPTION) || (cc == `DCI_CC_ATTN_EXC);
    endfunction : uses_isb

    function automatic logic legal_cc(input logic [2:0] cc);
        legal_cc = (cc != 3'h1) && (cc != 3'h5);
    endfunction : legal_cc

    assign dev_irq_ready = !pend && !ctl_end_owed;

    // Command sequencer
    always_ff @(posedge clk) begin
        if (clr_all) begin
            state        <= DCI_ST_IDLE;
            icb_done     <= 1'b0;
            icb_rdata    <= 16'h0000;
            icb_busy_cc6 <= 1'b0;
            icb_reject   <= 1'b0;
            dev_strobe   <= 1'b0;
            dev_kind     <= DCI_CMD_NONE;
            dev_command  <= 8'h00;
            dev_address  <= 8'h00;
            dev_wdata    <= 16'h0000;
            dev_reset    <= 1'b0;
        end else begin
            icb_done     <= 1'b0;
            icb_busy_cc6 <= 1'b0;
            icb_reject   <= 1'b0;
            dev_strobe   <= 1'b0;
            dev_reset    <= 1'b0;
            unique case (state)
                DCI_ST_IDLE: begin
                    if (icb_valid) begin
                        dev_command <= icb.command;
                        dev_address <= icb.address;
                        dev_kind    <= kind;
                        dev_wdata   <= icb.data;
                        if (kind == DCI_CMD_RESERVED) begin
                            icb_done   <= 1'b1;
                            icb_reject <= 1'b1;
                        end else if (kind == DCI_CMD_DEVRESET) begin
                            dev_reset <= 1'b1;
                            icb_done  <= 1'b1;
                        end else if (dev_busy) begin
                            icb_done     <= 1'b1;
                            icb_busy_cc6 <= 1'b1;
                        end else begin
                            dev_strobe <= 1'b1;
                            state      <= DCI_ST_WAIT;
                        end
                    end
                end
                DCI_ST_WAIT: begin
                    if (dev_ready) begin
                        icb_done <= 1'b1;
                        if (dev_kind == DCI_CMD_READ
                            || dev_kind == DCI_CMD_STATUS) begin
                            icb_rdata <= dev_rdata;
                        end else begin
                            icb_rdata <= 16'h0000;
                        end
                        state <= DCI_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Controller-free owed after a busy answer
    always_ff @(posedge clk) begin
        if (clr_all) begin
            ctl_end_owed <= 1'b0;
        end else if (icb_busy_cc6) begin
            ctl_end_owed <= 1'b1;
        end else if (ctl_end_owed && !pend && !dev_busy) begin
            ctl_end_owed <= 1'b0;
        end
    end

    // Interrupt holding; set wins over acceptance in the same cycle
    always_ff @(posedge clk) begin
        if (clr_all) begin
            pend      <= 1'b0;
            irq_pres  <= '0;
            interrupt_status_byte       <= `DCI_ISB_RST;
            pend_addr <= 8'h00;
        end else if (dev_reset && pend && pend_addr == dev_address) begin
            pend <= 1'b0;
            interrupt_status_byte  <= `DCI_ISB_RST;
        end else if (ctl_end_owed && !pend && !dev_busy) begin
            pend          <= 1'b1;
            pend_addr     <= GROUP_LOW_ADDR;
            irq_pres.cc   <= `DCI_CC_CTL_END;
            irq_pres.word <= {8'h00, GROUP_LOW_ADDR};
        end else if (dev_irq_valid && dev_irq_ready
                     && legal_cc(dev_irq.cc)) begin
            pend        <= 1'b1;
            pend_addr   <= dev_irq.address;
            irq_pres.cc <= dev_irq.cc;
            if (uses_isb(dev_irq.cc)) begin
                // Zero status only passes when the code alone suffices
                // Byte bits count from the top end, as in the word
                interrupt_status_byte <= (dev_irq.info == 8'h00 && !dev_irq.singular)
                       ? (8'h80 >> `DCI_ISB_DDS_BIT)
                       : dev_irq.info;
                irq_pres.word <= {(dev_irq.info == 8'h00
                                   && !dev_irq.singular)
                                  ? (8'h80 >> `DCI_ISB_DDS_BIT)
                                  : dev_irq.info,
                                  dev_irq.address};
            end else begin
                irq_pres.word <= {dev_irq.info, dev_irq.address};
            end
        end else if (pend && irq_ack) begin
            pend <= 1'b0;
            interrupt_status_byte  <= `DCI_ISB_RST;
        end
    end

    assign irq_req = pend;

    // Diagnostic mode and registers
    always_ff @(posedge clk) begin
        if (clr_all) begin
            diag_mode  <= 1'b0;
            diag_reg   <= 16'h0000;
            status_reg <= 16'h0000;
        end else begin
            if (diag_set) begin
                diag_mode <= 1'b1;
            end
            if (diag_mode && state == DCI_ST_WAIT && dev_ready) begin
                diag_reg <= dev_rdata;
            end
            status_reg <= {7'h00, ctl_end_owed, interrupt_status_byte};
        end
    end
endmodule : dci_core

// ### tb/dci_core_props.sv
`timescale 1ns/1ns
module dci_core_props
    import dci_pkg::*;
#(
    parameter logic [7:0] GROUP_LOW_ADDR = 8'h00
)(
    input wire logic          clk,
    input wire logic          rstn,
    input wire logic          icb_done,
    input wire logic [15:0]   icb_rdata,
    input wire logic          icb_busy_cc6,
    input wire logic          icb_reject,
    input wire logic          sys_reset,
    input wire logic          halt_io,
    input wire logic          machine_check,
    input wire logic          diag_mode,
    input wire logic [15:0]   diag_reg,
    input wire logic [15:0]   status_reg,
    input wire logic          irq_req,
    input dci_pkg::dci_ipres_s irq_pres,
    input wire logic          irq_ack,
    input wire logic          dev_strobe,
    input dci_pkg::dci_cmd_e  dev_kind,
    input wire logic [15:0]   dev_rdata,
    input wire logic          dev_irq_valid,
    input dci_pkg::dci_irq_s  dev_irq,
    input wire logic          dev_irq_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire acc = dev_irq_valid && dev_irq_ready;
    // A clear in the same cycle wins over a new interrupt
    wire clr = sys_reset || halt_io || machine_check;
    no_code15_a: assert property (
        irq_req |-> !(irq_pres.cc inside {3'h1, 3'h5}))
        else $error("Forbidden condition code presented");
    word_map_a: assert property (
        acc && !clr && !(dev_irq.cc inside {3'h1, 3'h5})
        |=> irq_req && irq_pres.cc == $past(dev_irq.cc)
        && irq_pres.word[7:0] == $past(dev_irq.address))
        else $error("Interrupt word wrong");
    info_byte_a: assert property (
        acc && !clr && dev_irq.cc inside {3'h3, 3'h4, 3'h7}
        |=> irq_pres.word[15:8] == $past(dev_irq.info))
        else $error("Info byte wrong");
    isb_nonzero_a: assert property (
        acc && !clr && dev_irq.cc inside {3'h2, 3'h6} && !dev_irq.singular
        |=> irq_pres.word[15:8] != 8'h00)
        else $error("Status byte zero");
    ctl_end_a: assert property (
        irq_req && irq_pres.cc == 3'h0
        |-> irq_pres.word == {8'h00, GROUP_LOW_ADDR})
        else $error("Controller end word wrong");
    ack_clear_a: assert property (
        irq_req && irq_ack |=> !irq_req)
        else $error("Interrupt not cleared on accept");
    reset_clear_a: assert property (
        clr |=> !diag_mode && diag_reg == 16'h0000
        && status_reg == 16'h0000)
        else $error("Reset left state");
    read_move_a: assert property (
        icb_done && !icb_reject && !icb_busy_cc6
        && dev_kind inside {DCI_CMD_READ, DCI_CMD_STATUS}
        |-> icb_rdata == $past(dev_rdata))
        else $error("Read word wrong");
    strobe_kind_a: assert property (
        dev_strobe |-> dev_kind inside {DCI_CMD_READ, DCI_CMD_STATUS,
        DCI_CMD_WRITE, DCI_CMD_CONTROL})
        else $error("Bad strobe kind");
endmodule : dci_core_props
bind dci_core dci_core_props #(
    .GROUP_LOW_ADDR (GROUP_LOW_ADDR)
) dci_core_props_i (
    .clk           (clk),
    .rstn          (rstn),
    .icb_done      (icb_done),
    .icb_rdata     (icb_rdata),
    .icb_busy_cc6  (icb_busy_cc6),
    .icb_reject    (icb_reject),
    .sys_reset     (sys_reset),
    .halt_io       (halt_io),
    .machine_check (machine_check),
    .diag_mode     (diag_mode),
    .diag_reg      (diag_reg),
    .status_reg    (status_reg),
    .irq_req       (irq_req),
    .irq_pres      (irq_pres),
    .irq_ack       (irq_ack),
    .dev_strobe    (dev_strobe),
    .dev_kind      (dev_kind),
    .dev_rdata     (dev_rdata),
    .dev_irq_valid (dev_irq_valid),
    .dev_irq       (dev_irq),
    .dev_irq_ready (dev_irq_ready)
);

// ### tb/dci_dev_model.sv
`timescale 1ns/1ns
module dci_dev_model
    import dci_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         dev_strobe,
    input  dci_pkg::dci_cmd_e dev_kind,
    input  wire logic [7:0]   dev_address,
    output logic              dev_ready,
    output logic [15:0]       dev_rdata
);
    import dci_pkg::*;
    logic [2:0] cnt;
    // Odd addresses answer slowly; stale data is inverted every cycle, so it matches the last word only every other cycle
    always_ff @(posedge clk) begin
        dev_ready <= 1'b0;
        dev_rdata <= ~dev_rdata;
        if (!rstn) begin
            cnt <= 3'h0;
        end else if (dev_strobe) begin
            cnt <= dev_address[0] ? 3'h4 : 3'h1;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
                dev_ready <= 1'b1;
                dev_rdata <= {dev_address, (dev_kind == DCI_CMD_STATUS) ? 8'h5a : 8'ha5};
            end
        end
    end
endmodule : dci_dev_model

// ### tb/dci_core_test.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR %0t mismatch %h vs %h", $time, a, b); end end
module dci_core_test;
    import dci_pkg::*;
    logic clk = 0, rstn = 0, icb_valid = 0, sys_reset = 0, halt_io = 0;
    logic machine_check = 0, diag_set = 0, irq_ack = 0, dev_busy = 0;
    logic dev_irq_valid = 0, icb_done, icb_busy_cc6, icb_reject, diag_mode;
    logic irq_req, dev_strobe, dev_reset, dev_ready, dev_irq_ready, seen, rst;
    logic [7:0] dev_command, dev_address;
    logic [15:0] icb_rdata, diag_reg, status_reg, dev_wdata, dev_rdata, w;
    dci_icb_s icb = '0;
    dci_irq_s dev_irq = '0;
    dci_ipres_s irq_pres;
    dci_cmd_e dev_kind, k;
    int n_fail = 0, n_checks = 0, cyc = 0;
    dci_core #(.GROUP_LOW_ADDR(8'h10)) dci_core_i (
        .clk(clk), .rstn(rstn), .icb_valid(icb_valid), .icb(icb),
        .icb_done(icb_done), .icb_rdata(icb_rdata),
        .icb_busy_cc6(icb_busy_cc6), .icb_reject(icb_reject),
        .sys_reset(sys_reset), .halt_io(halt_io),
        .machine_check(machine_check), .diag_set(diag_set),
        .diag_mode(diag_mode), .diag_reg(diag_reg),
        .status_reg(status_reg), .irq_req(irq_req), .irq_pres(irq_pres),
        .irq_ack(irq_ack), .dev_strobe(dev_strobe), .dev_kind(dev_kind),
        .dev_command(dev_command), .dev_address(dev_address),
        .dev_wdata(dev_wdata), .dev_reset(dev_reset),
        .dev_ready(dev_ready), .dev_rdata(dev_rdata), .dev_busy(dev_busy),
        .dev_irq_valid(dev_irq_valid), .dev_irq(dev_irq),
        .dev_irq_ready(dev_irq_ready));
    dci_dev_model dci_dev_model_i (.clk(clk), .rstn(rstn), .dev_strobe(dev_strobe),
        .dev_kind(dev_kind), .dev_address(dev_address), .dev_ready(dev_ready),
        .dev_rdata(dev_rdata));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic step;
        @(posedge clk);
        #2;
    endtask : step
    task automatic end_of_test;
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test;
        end
    end
    task automatic cmd(input logic [7:0] c, a, input logic [15:0] d);
        icb_valid = 1;
        icb = {c, a, d};
        seen = 0;
        rst = 0;
        step;
        icb_valid = 0;
        for (int i = 0; i < 20 && icb_done !== 1'b1; i++) begin
            if (dev_strobe === 1'b1) begin
                seen = 1'b1;
                k = dev_kind;
                w = dev_wdata;
            end
            rst |= dev_reset;
            step;
        end
        rst |= dev_reset;
    endtask : cmd
    task automatic irq(input logic [2:0] c, input logic [7:0] f, a,
                       input logic s, input logic [7:0] x, input logic ack);
        dev_irq_valid = 1;
        dev_irq = {c, f, a, s};
        for (int i = 0; i < 20 && dev_irq_ready !== 1'b1; i++) step;
        step;
        dev_irq_valid = 0;
        if (c == 3'h1 || c == 3'h5) `CHK(irq_req, 1'b0)
        else `CHK(irq_pres, {c, x, a})
        if (ack) begin
            irq_ack = 1;
            step;
            irq_ack = 0;
            `CHK(irq_req, 1'b0)
        end
    endtask : irq
    initial begin
        step;
        step;
        rstn = 1;
        `CHK({irq_req, status_reg, dev_irq_ready}, 18'h00001)
        // Read, status, write, control in every nibble of the table
        cmd(8'h03, 8'h21, 16'h0); `CHK({k, icb_rdata}, {DCI_CMD_READ, 16'h21a5})
        cmd(8'h1a, 8'h40, 16'h0); `CHK({k, icb_rdata}, {DCI_CMD_READ, 16'h40a5})
        cmd(8'h25, 8'h33, 16'h0); `CHK({k, icb_rdata}, {DCI_CMD_STATUS, 16'h335a})
        cmd(8'h40, 8'h12, 16'hbeef); `CHK({k, w}, {DCI_CMD_WRITE, 16'hbeef})
        cmd(8'h5f, 8'h13, 16'h0f0f); `CHK({k, w}, {DCI_CMD_WRITE, 16'h0f0f})
        cmd(8'h61, 8'h14, 16'h1234); `CHK({k, seen}, {DCI_CMD_CONTROL, 1'b1})
        `CHK({dev_command, dev_address}, 16'h6114)
        cmd(8'h33, 8'h14, 16'h0); `CHK({icb_reject, seen}, 2'b10)
        cmd(8'h80, 8'h14, 16'h0); `CHK({icb_reject, seen}, 2'b10)
        irq(3'h2, 8'h00, 8'h11, 1'b0, 8'h80, 1);
        irq(3'h2, 8'hc2, 8'h12, 1'b0, 8'hc2, 1);
        irq(3'h3, 8'h7e, 8'h13, 1'b0, 8'h7e, 1);
        irq(3'h4, 8'h00, 8'h14, 1'b1, 8'h00, 1);
        irq(3'h6, 8'h40, 8'h15, 1'b0, 8'h40, 1);
        irq(3'h7, 8'h3c, 8'h16, 1'b0, 8'h3c, 1);
        irq(3'h1, 8'h55, 8'h17, 1'b0, 8'h00, 0);
        irq(3'h5, 8'h55, 8'h18, 1'b0, 8'h00, 0);
        irq(3'h3, 8'h01, 8'h22, 1'b0, 8'h01, 0);
        cmd(8'h2f, 8'h22, 16'h0);
        step;
        `CHK({irq_req, rst}, 2'b01)
        dev_busy = 1;
        cmd(8'h40, 8'h33, 16'h0); `CHK(icb_busy_cc6, 1'b1)
        dev_busy = 0;
        for (int i = 0; i < 20 && irq_req !== 1'b1; i++) step;
        `CHK(irq_pres, {3'h0, 8'h00, 8'h10})
        `CHK(status_reg, 16'h0100)
        irq_ack = 1;
        step;
        irq_ack = 0;
        for (int j = 0; j < 3; j++) begin
            diag_set = 1;
            step;
            diag_set = 0;
            `CHK(diag_mode, 1'b1)
            cmd(8'h00, 8'h20, 16'h0);
            `CHK(diag_reg, 16'h20a5)
            {sys_reset, halt_io, machine_check} = 3'b001 << j;
            step;
            {sys_reset, halt_io, machine_check} = 3'b000;
            `CHK({diag_mode, diag_reg, status_reg}, 33'h0)
        end
        end_of_test;
    end
endmodule : dci_core_test
